// *** hdl/aij_consts.svh ***
`ifndef AIJ_CONSTS_SVH
`define AIJ_CONSTS_SVH

// Register word offsets
`define AIJ_OFF_CTRL      4'h0
`define AIJ_OFF_STD_RES   4'h1
`define AIJ_OFF_ALT_RES   4'h2
`define AIJ_OFF_STATUS    4'h3
`define AIJ_OFF_IRQ_STAT  4'h4
`define AIJ_OFF_IRQ_EN    4'h5
`define AIJ_OFF_IRQ_CLR   4'h6
`define AIJ_OFF_STATE     4'h7

// Control fields
`define AIJ_CTRL_WAIT_RD  0
`define AIJ_CTRL_INJ_EN   1
`define AIJ_CTRL_RESET    16'h0000

// Interrupt status fields
`define AIJ_IRQ_INJ_DONE  0
`define AIJ_IRQ_STD_DONE  1
`define AIJ_IRQ_STALL     2
`define AIJ_IRQ_BITS      3

// Converter timing: 10 us per conversion at 50 ns per cycle
`define AIJ_CONV_TIME_NS  10000
`define AIJ_CLK_PERIOD_NS 50
`define AIJ_CONV_CYCLES   (`AIJ_CONV_TIME_NS / `AIJ_CLK_PERIOD_NS)

`endif

// *** hdl/aij_pkg.sv ***
package aij_pkg;
    typedef enum logic [1:0] {
        AIJ_IDLE = 2'b00,
        AIJ_CONV = 2'b01,
        AIJ_DONE = 2'b11,
        AIJ_WAIT = 2'b10
    } aij_state_e;

    typedef logic [15:0] aij_word_t;
endpackage

// *** hdl/aij_conv_if.sv ***
`timescale 1ns/1ns
interface aij_conv_if;
    logic             start;
    logic             inj;
    logic             busy;
    logic             done;
    logic             done_inj;
    aij_pkg::aij_word_t data;

    modport ctl (output start, output inj, input busy, input done, input done_inj, input data);
    modport core(input start, input inj, output busy, output done, output done_inj, output data);
endinterface

// *** hdl/aij_conv_timer.sv ***
`timescale 1ns/1ns
`include "aij_consts.svh"
module aij_conv_timer #(
    parameter int CONV_CYCLES = `AIJ_CONV_CYCLES
) (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  arst_n,
    // Sample from the analog side
    input  wire logic [15:0] sample,
    // Towards the controller
    aij_conv_if.core   cv
);
    localparam int CW = $clog2(CONV_CYCLES + 1);

    // Elaboration refuses a converter that could never finish
    if (CONV_CYCLES < 1) begin : g_bad_cycles
        $error("CONV_CYCLES must be at least one");
    end

    logic [CW-1:0]      cnt_r;
    logic               busy_r;
    logic               inj_r;
    logic               done_r;
    aij_pkg::aij_word_t data_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            inj_r  <= 1'b0;
            done_r <= 1'b0;
            data_r <= 16'h0000;
        end else begin
            done_r <= 1'b0;
            if (!busy_r && cv.start) begin
                busy_r <= 1'b1;
                inj_r  <= cv.inj;
                cnt_r  <= CW'(CONV_CYCLES - 1);
            end else if (busy_r) begin
                if (cnt_r == '0) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    data_r <= sample;
                end else begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    end

    assign cv.busy     = busy_r;
    assign cv.done     = done_r;
    assign cv.done_inj = inj_r;
    assign cv.data     = data_r;
endmodule

// *** hdl/aij_result_ctl.sv ***
`timescale 1ns/1ns
`include "aij_consts.svh"
// Notes on behaviour
// - Injection converts one channel, mode unchanged
// - Injected result to alternate register, flag set
// - Full holding register suspends next conversion
// - Injection while unread, with wait-for-read set, stays in holding register
// - Alternate read moves held value, raises request
// - Capture/compare trigger channel starts injection
// - Stalled: no further conversions
// - Toggling wait-for-read releases stall
module aij_result_ctl #(
    parameter int CONV_CYCLES = `AIJ_CONV_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Converter side
    input  wire logic [15:0] sample,
    input  wire logic        capcom_trigger_channel,
    input  wire logic        std_req,
    // Results and requests
    output logic             injection_done_irq,
    output logic             irq
);
    aij_conv_if cv();

    aij_conv_timer #(.CONV_CYCLES(CONV_CYCLES)) u_timer (
        .mclk  (mclk),
        .arst_n(arst_n),
        .sample(sample),
        .cv    (cv)
    );

    ////////////////////////////////////////////////////////////////////////
    // Trigger synchroniser: the pin is outside the clock domain
    logic [2:0] trg_sync_r;
    logic       trg_lvl_r;
    logic       trg_pend_r;
    logic       std_pend_r;
    logic       trg_rise;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trg_sync_r <= 3'b000;
            trg_lvl_r  <= 1'b0;
        end else begin
            trg_sync_r <= {trg_sync_r[1:0], capcom_trigger_channel};
            if (trg_sync_r[1] == trg_sync_r[2])
                trg_lvl_r <= trg_sync_r[2];
        end
    end

    assign trg_rise = (trg_sync_r[1] == trg_sync_r[2]) && trg_sync_r[2] && !trg_lvl_r;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0]                   ctrl_r;
    aij_pkg::aij_word_t            std_res_r;
    aij_pkg::aij_word_t            alt_res_r;
    aij_pkg::aij_word_t            hold_r;
    logic                          hold_full_r;
    logic                          hold_inj_r;
    logic                          alt_unread_r;
    logic                          stall_r;
    logic                          wait_en_q_r;
    logic [`AIJ_IRQ_BITS-1:0]      irq_stat_r;
    logic [`AIJ_IRQ_BITS-1:0]      irq_en_r;
    aij_pkg::aij_state_e           state_r;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    logic wait_en;
    logic alt_rd;
    logic toggle_release;

    assign wait_en        = ctrl_r[`AIJ_CTRL_WAIT_RD];
    assign alt_rd         = rd && hit(addr, `AIJ_OFF_ALT_RES);
    assign toggle_release = wait_en && !wait_en_q_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r      <= `AIJ_CTRL_RESET;
            irq_en_r    <= '0;
            wait_en_q_r <= 1'b0;
        end else begin
            wait_en_q_r <= wait_en;
            if (wr && hit(addr, `AIJ_OFF_CTRL))
                ctrl_r <= wdata;
            if (wr && hit(addr, `AIJ_OFF_IRQ_EN))
                irq_en_r <= wdata[`AIJ_IRQ_BITS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending requests, held until the converter can take them
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trg_pend_r <= 1'b0;
            std_pend_r <= 1'b0;
        end else begin
            if (trg_rise && ctrl_r[`AIJ_CTRL_INJ_EN])
                trg_pend_r <= 1'b1;
            else if (cv.start && cv.inj)
                trg_pend_r <= 1'b0;
            if (std_req)
                std_pend_r <= 1'b1;
            else if (cv.start && !cv.inj)
                std_pend_r <= 1'b0;
        end
    end

    // Injection wins arbitration but leaves the standard request pending
    logic can_start;
    assign can_start = (state_r == aij_pkg::AIJ_IDLE) && !hold_full_r && !stall_r;
    assign cv.start  = can_start && (trg_pend_r || std_pend_r);
    assign cv.inj    = trg_pend_r;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= aij_pkg::AIJ_IDLE;
        end else begin
            case (state_r)
                aij_pkg::AIJ_IDLE: if (cv.start) state_r <= aij_pkg::AIJ_CONV;
                aij_pkg::AIJ_CONV: if (cv.done)  state_r <= aij_pkg::AIJ_DONE;
                aij_pkg::AIJ_DONE: state_r <= hold_full_r ? aij_pkg::AIJ_WAIT
                                                          : aij_pkg::AIJ_IDLE;
                aij_pkg::AIJ_WAIT: if (!hold_full_r) state_r <= aij_pkg::AIJ_IDLE;
                default:           state_r <= aij_pkg::AIJ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result path
    logic inj_done_evt;
    logic std_done_evt;
    logic stall_evt;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            std_res_r    <= 16'h0000;
            alt_res_r    <= 16'h0000;
            hold_r       <= 16'h0000;
            hold_full_r  <= 1'b0;
            hold_inj_r   <= 1'b0;
            alt_unread_r <= 1'b0;
            stall_r      <= 1'b0;
            inj_done_evt <= 1'b0;
            std_done_evt <= 1'b0;
            stall_evt    <= 1'b0;
        end else begin
            inj_done_evt <= 1'b0;
            std_done_evt <= 1'b0;
            stall_evt    <= 1'b0;
            if (toggle_release) begin
                stall_r     <= 1'b0;
                hold_full_r <= 1'b0;
            end else if (cv.done) begin
                if (cv.done_inj && wait_en && alt_unread_r) begin
                    hold_r      <= cv.data;
                    hold_inj_r  <= 1'b1;
                    hold_full_r <= 1'b1;
                end else if (cv.done_inj) begin
                    alt_res_r    <= cv.data;
                    alt_unread_r <= 1'b1;
                    inj_done_evt <= 1'b1;
                end else if (wait_en && alt_unread_r) begin
                    hold_r      <= cv.data;
                    hold_inj_r  <= 1'b0;
                    hold_full_r <= 1'b1;
                end else begin
                    std_res_r    <= cv.data;
                    std_done_evt <= 1'b1;
                end
            end else if (alt_rd) begin
                if (hold_full_r && !stall_r) begin
                    if (hold_inj_r) begin
                        alt_res_r    <= hold_r;
                        inj_done_evt <= 1'b1;
                    end else begin
                        std_res_r    <= hold_r;
                        std_done_evt <= 1'b1;
                        alt_unread_r <= 1'b0;
                    end
                    hold_full_r <= 1'b0;
                end else if (!hold_full_r) begin
                    alt_unread_r <= 1'b0;
                end
            end else if (hold_full_r && trg_pend_r && !stall_r) begin
                // New injection while full: no way out but the mode toggle
                stall_r   <= 1'b1;
                stall_evt <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over clear
    logic [`AIJ_IRQ_BITS-1:0] irq_set;
    logic [`AIJ_IRQ_BITS-1:0] irq_clr;
    assign irq_set = {stall_evt, std_done_evt, inj_done_evt};
    assign irq_clr = (wr && hit(addr, `AIJ_OFF_IRQ_CLR)) ? wdata[`AIJ_IRQ_BITS-1:0] : '0;

    // Next enable, so the level never lags an enable write
    logic [`AIJ_IRQ_BITS-1:0] irq_en_nxt;
    assign irq_en_nxt = (wr && hit(addr, `AIJ_OFF_IRQ_EN)) ? wdata[`AIJ_IRQ_BITS-1:0]
                                                          : irq_en_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_r         <= '0;
            injection_done_irq <= 1'b0;
            irq                <= 1'b0;
        end else begin
            irq_stat_r         <= (irq_stat_r & ~irq_clr) | irq_set;
            injection_done_irq <= inj_done_evt;
            irq                <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_nxt);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `AIJ_OFF_CTRL:     rdata <= ctrl_r;
                `AIJ_OFF_STD_RES:  rdata <= std_res_r;
                `AIJ_OFF_ALT_RES:  rdata <= alt_res_r;
                `AIJ_OFF_STATUS:   rdata <= {12'h000, stall_r, hold_full_r,
                                             alt_unread_r, cv.busy};
                `AIJ_OFF_IRQ_STAT: rdata <= {13'h0000, irq_stat_r};
                `AIJ_OFF_IRQ_EN:   rdata <= {13'h0000, irq_en_r};
                `AIJ_OFF_STATE:    rdata <= {14'h0000, state_r};
                default:           rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_no_start_full;
        @(posedge mclk) disable iff (!arst_n) hold_full_r |-> !cv.start;
    endproperty
    a_no_start_full: assert property (p_no_start_full) else $error("start while full");

    property p_no_start_stall;
        @(posedge mclk) disable iff (!arst_n) stall_r |-> !cv.start;
    endproperty
    a_no_start_stall: assert property (p_no_start_stall) else $error("start while stalled");

    property p_inj_done;
        @(posedge mclk) disable iff (!arst_n)
            (cv.done && cv.done_inj && !alt_unread_r && !toggle_release)
            |=> (alt_res_r == $past(cv.data)) && alt_unread_r ##1 injection_done_irq;
    endproperty
    a_inj_done: assert property (p_inj_done) else $error("injected result lost");

    property p_move;
        @(posedge mclk) disable iff (!arst_n)
            (alt_rd && hold_full_r && hold_inj_r && !stall_r && !cv.done && !toggle_release)
            |=> !hold_full_r && alt_res_r == $past(hold_r) ##1 injection_done_irq;
    endproperty
    a_move: assert property (p_move) else $error("held value not moved");

    property p_hold;
        @(posedge mclk) disable iff (!arst_n)
            (cv.done && cv.done_inj && wait_en && alt_unread_r && !toggle_release)
            |=> hold_full_r && hold_r == $past(cv.data) && $stable(alt_res_r);
    endproperty
    a_hold: assert property (p_hold) else $error("injection not held");

    property p_stall;
        @(posedge mclk) disable iff (!arst_n)
            (hold_full_r && trg_pend_r && !toggle_release && !cv.done && !alt_rd) |=> stall_r;
    endproperty
    a_stall: assert property (p_stall) else $error("stall not entered");

    property p_release;
        @(posedge mclk) disable iff (!arst_n) toggle_release |=> !stall_r && !hold_full_r;
    endproperty
    a_release: assert property (p_release) else $error("stall not released");

    property p_trig;
        @(posedge mclk) disable iff (!arst_n)
            (trg_rise && ctrl_r[`AIJ_CTRL_INJ_EN]) |=> trg_pend_r;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger missed");

    property p_irq;
        @(posedge mclk) disable iff (!arst_n) irq == |(irq_stat_r & irq_en_r);
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    c_inj:   cover property (@(posedge mclk) cv.start && cv.inj);
    c_hold:  cover property (@(posedge mclk) $rose(hold_full_r));
    c_stall: cover property (@(posedge mclk) $rose(stall_r));
    c_move:  cover property (@(posedge mclk) alt_rd && hold_full_r && !stall_r);
endmodule

// *** sim/aij_evt_reader.sv ***
`timescale 1ns/1ns
module aij_evt_reader (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Control from the bench
    input  wire logic        on,
    input  wire logic [7:0]  lag,
    // Request and answer
    input  wire logic        injection_done_irq,
    output logic             rd_req,
    input  wire logic [15:0] rdata,
    output logic [15:0]      got,
    output logic             got_v
);
    logic [7:0] cnt_r;
    logic       arm_r;
    logic       take_r;

    // One read per request, like an event-driven transfer channel
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r  <= 8'h00;
            arm_r  <= 1'b0;
            rd_req <= 1'b0;
            take_r <= 1'b0;
            got    <= 16'h0000;
            got_v  <= 1'b0;
        end else begin
            rd_req <= 1'b0;
            take_r <= rd_req;
            if (take_r) begin
                got   <= rdata;
                got_v <= 1'b1;
            end
            if (on && injection_done_irq) begin
                arm_r <= 1'b1;
                cnt_r <= lag;
                got_v <= 1'b0;
            end else if (arm_r && cnt_r == 8'h00) begin
                arm_r  <= 1'b0;
                rd_req <= 1'b1;
            end else if (arm_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
            // Stale answer dropped while the channel is off
            if (!on)
                got_v <= 1'b0;
        end
    end
endmodule

// *** sim/adc_injection_result_path_tb.sv ***
`timescale 1ns/1ns
module adc_injection_result_path_tb;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic [15:0] sample = 16'h0000;
    logic        trg = 1'b0;
    logic        std_req = 1'b0;
    logic        injection_done_irq;
    logic        irq;
    logic        pe_on = 1'b0;
    logic [7:0]  pe_lag = 8'h00;
    logic        pe_rd;
    logic [15:0] pe_got;
    logic        pe_got_v;
    logic [15:0] v;
    int          n_errors = 0;
    int          samples_checked = 0;

    always #25 mclk = ~mclk;

    aij_result_ctl #(.CONV_CYCLES(4)) aij_result_ctl_i (
        .mclk(mclk), .arst_n(arst_n), .addr(pe_rd ? 4'h2 : addr), .wdata(wdata),
        .wr(wr), .rd(rd | pe_rd), .rdata(rdata), .sample(sample),
        .capcom_trigger_channel(trg), .std_req(std_req),
        .injection_done_irq(injection_done_irq), .irq(irq)
    );

    aij_evt_reader aij_evt_reader_i (
        .mclk(mclk), .arst_n(arst_n), .on(pe_on), .lag(pe_lag),
        .injection_done_irq(injection_done_irq), .rd_req(pe_rd), .rdata(rdata),
        .got(pe_got), .got_v(pe_got_v)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic trig(input logic [15:0] s);
        @(posedge mclk);
        sample <= s;
        trg <= 1'b1;
        repeat (4) @(posedge mclk);
        trg <= 1'b0;
    endtask

    task automatic wait_irq;
        int i;
        for (i = 0; i < 60 && injection_done_irq !== 1'b1; i++)
            @(posedge mclk) #1;
        chk({15'h0000, injection_done_irq}, 16'h0001);
        if (injection_done_irq !== 1'b1) wrap_up();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(4'h3, v);
        chk(v, 16'h0000);
        rd_reg(4'h4, v);
        chk(v, 16'h0000);
        rd_reg(4'h8, v);
        chk(v, 16'h0000);
    endtask

    task automatic t_single;
        wr_reg(4'h0, 16'h0003);
        wr_reg(4'h5, 16'h0001);
        trig(16'hC3A1);
        wait_irq();
        repeat (2) @(posedge mclk);
        #1 chk({15'h0000, irq}, 16'h0001);
        rd_reg(4'h4, v);
        chk(v & 16'h0001, 16'h0001);
        rd_reg(4'h2, v);
        chk(v, 16'hC3A1);
        rd_reg(4'h2, v);
        chk(v, 16'hC3A1);
        wr_reg(4'h6, 16'h0001);
        repeat (2) @(posedge mclk);
        #1 chk({15'h0000, irq}, 16'h0000);
    endtask

    task automatic t_held;
        trig(16'hA5A5);
        wait_irq();
        trig(16'h5A5A);
        repeat (30) @(posedge mclk);
        rd_reg(4'h3, v);
        chk(v & 16'h0004, 16'h0004);
        rd_reg(4'h2, v);
        chk(v, 16'hA5A5);
        wait_irq();
        rd_reg(4'h2, v);
        chk(v, 16'h5A5A);
    endtask

    task automatic t_stall;
        trig(16'h1111);
        wait_irq();
        trig(16'h2222);
        repeat (30) @(posedge mclk);
        trig(16'h3333);
        repeat (30) @(posedge mclk);
        rd_reg(4'h3, v);
        chk(v & 16'h0008, 16'h0008);
        // Toggling wait-for-read is the only way out
        wr_reg(4'h0, 16'h0002);
        wr_reg(4'h0, 16'h0003);
        rd_reg(4'h3, v);
        chk(v & 16'h0008, 16'h0000);
        rd_reg(4'h2, v);
        chk(v, 16'h1111);
        // The trigger left pending by the stall converts once released
        wait_irq();
        rd_reg(4'h2, v);
        chk(v, 16'h3333);
    endtask

    task automatic t_std;
        trig(16'h4444);
        wait_irq();
        @(posedge mclk);
        sample  <= 16'h6666;
        std_req <= 1'b1;
        @(posedge mclk);
        std_req <= 1'b0;
        repeat (20) @(posedge mclk);
        rd_reg(4'h3, v);
        chk(v, 16'h0006);
        rd_reg(4'h1, v);
        chk(v, 16'h0000);
        rd_reg(4'h2, v);
        chk(v, 16'h4444);
        rd_reg(4'h1, v);
        chk(v, 16'h6666);
        rd_reg(4'h3, v);
        chk(v, 16'h0000);
    endtask

    task automatic t_mid_reset;
        trig(16'h8888);
        wait_irq();
        trig(16'h9999);
        repeat (30) @(posedge mclk);
        rd_reg(4'h3, v);
        chk(v, 16'h0006);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
    endtask

    task automatic t_partner(input logic [7:0] lag, input logic [15:0] s);
        int i;
        pe_on <= 1'b1;
        pe_lag <= lag;
        trig(s);
        for (i = 0; i < 100 && pe_got_v !== 1'b1; i++)
            @(posedge mclk) #1;
        chk({15'h0000, pe_got_v}, 16'h0001);
        chk(pe_got, s);
        pe_on <= 1'b0;
        repeat (30) @(posedge mclk);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_single();
        t_held();
        t_stall();
        t_std();
        t_partner(8'h00, 16'h7777);
        t_partner(8'h14, 16'h0F0F);
        t_mid_reset();
        wrap_up();
    end
endmodule
